// ===== hdl/wdlvh_top.sv
// watchdog and low-voltage hold supervisor, top level
//
// What this block does
// - The countdown raises chip reset when it reaches the one-second count uncleared.
// - The countdown runs from reset release and nothing can disable it; it is held at zero only while chip reset or wdt_clear is high.
// - A filtered low-supply flag below 2.1 V puts the chip into hold, suspending execution.
// - When the flag shows the supply back at 2.1 V, hold ends and execution resumes in place.
// - Entry into hold waits for the current instruction to finish.
// - The internal ring oscillator keeps running during hold.
// - During hold the state update enable is low so the latches, registers and RAM it gates keep value; the watchdog countdown keeps counting.
// - The supervisor counters run on a 2 MHz system tick divided from the master clock.
`timescale 1ns/100ps
`include "wdlvh_regs.svh"

module wdlvh_top
    import wdlvh_pkg::*;
#(
    parameter int DIV_RATIO = `WDLVH_DIV_RATIO,
    parameter int TIMEOUT_TICKS = int'(`WDLVH_WDT_TICKS),
    parameter int RST_PULSE_TICKS = `WDLVH_RST_PULSE_TICKS,
    parameter int LV_FILTER_TICKS = `WDLVH_LV_FILTER_TICKS
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic wdt_clear,
    input wire logic low_voltage,
    input wire logic instr_done,
    output logic chip_reset,
    output logic hold_active,
    output logic hold_pending,
    output logic state_update_en,
    output logic sys_tick,
    output logic internal_ring_osc_en,
    output logic [`WDLVH_WDT_W-1:0] supervisory_countdown
);

    localparam logic [`WDLVH_DIV_W-1:0] DIV_LAST = `WDLVH_DIV_W'(DIV_RATIO - 1);
    localparam logic [`WDLVH_RST_W-1:0] RST_LAST = `WDLVH_RST_W'(RST_PULSE_TICKS - 1);
    localparam logic [`WDLVH_FLT_W-1:0] FLT_LAST = `WDLVH_FLT_W'(LV_FILTER_TICKS - 1);

    // refuse settings the counters cannot hold
    initial begin
        if (DIV_RATIO < 1 || DIV_RATIO > (1 << `WDLVH_DIV_W)) begin
            $error("wdlvh_top: DIV_RATIO out of range");
        end
        if (RST_PULSE_TICKS < 1 || RST_PULSE_TICKS > (1 << `WDLVH_RST_W)) begin
            $error("wdlvh_top: RST_PULSE_TICKS out of range");
        end
        if (LV_FILTER_TICKS < 1 || LV_FILTER_TICKS > (1 << `WDLVH_FLT_W)) begin
            $error("wdlvh_top: LV_FILTER_TICKS out of range");
        end
    end

    wdlvh_wdt_if wdt ();

    wdlvh_top_state_t s;
    wdlvh_top_state_t next_s;

    wdlvh_countdown #(
        .TIMEOUT_TICKS(TIMEOUT_TICKS)
    ) u_countdown (
        .clock(clock),
        .rst(rst),
        .wdt(wdt)
    );

    // tick, clear and expire all stay in the one clock domain
    assign wdt.tick = s.tick;
    assign wdt.clear = wdt_clear | s.chip_reset;

    always_comb begin
        next_s = s;

        next_s.tick = 1'b0;
        if (s.div == DIV_LAST) begin
            next_s.div = `WDLVH_ZERO_DIV;
            next_s.tick = 1'b1;
        end else begin
            next_s.div = s.div + `WDLVH_DIV_W'(1);
        end

        // the flag must differ from the believed level for a run of ticks
        if (low_voltage == s.lv_filt) begin
            next_s.flt = `WDLVH_ZERO_FLT;
        end else if (s.tick) begin
            if (s.flt == FLT_LAST) begin
                next_s.flt = `WDLVH_ZERO_FLT;
                next_s.lv_filt = low_voltage;
            end else begin
                next_s.flt = s.flt + `WDLVH_FLT_W'(1);
            end
        end

        if (wdt.expire) begin
            next_s.chip_reset = 1'b1;
            next_s.rst_cnt = `WDLVH_ZERO_RST;
        end else if (s.chip_reset && s.tick) begin
            if (s.rst_cnt == RST_LAST) begin
                next_s.chip_reset = 1'b0;
                next_s.rst_cnt = `WDLVH_ZERO_RST;
            end else begin
                next_s.rst_cnt = s.rst_cnt + `WDLVH_RST_W'(1);
            end
        end

        case (s.hold)
            WDLVH_RUN: begin
                if (s.lv_filt) begin
                    if (instr_done) begin
                        next_s.hold = WDLVH_HOLD;
                    end else begin
                        next_s.hold = WDLVH_PEND;
                    end
                end
            end
            WDLVH_PEND: begin
                if (!s.lv_filt) begin
                    next_s.hold = WDLVH_RUN;
                end else if (instr_done) begin
                    next_s.hold = WDLVH_HOLD;
                end
            end
            WDLVH_HOLD: begin
                if (!s.lv_filt) begin
                    next_s.hold = WDLVH_RUN;
                end
            end
            default: begin
                next_s.hold = WDLVH_RUN;
            end
        endcase

        // a watchdog reset restarts the whole chip, hold included
        if (s.chip_reset) begin
            next_s.hold = WDLVH_RUN;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            s.div <= `WDLVH_ZERO_DIV;
            s.tick <= 1'b0;
            s.hold <= WDLVH_RUN;
            s.flt <= `WDLVH_ZERO_FLT;
            s.lv_filt <= 1'b0;
            s.rst_cnt <= `WDLVH_ZERO_RST;
            s.chip_reset <= 1'b0;
        end else begin
            s <= next_s;
        end
    end

    assign chip_reset = s.chip_reset;
    assign hold_active = (s.hold == WDLVH_HOLD);
    assign hold_pending = (s.hold == WDLVH_PEND);
    assign sys_tick = s.tick;

    assign state_update_en = s.tick & ~hold_active & ~s.chip_reset;

    assign internal_ring_osc_en = 1'b1;

    assign supervisory_countdown = wdt.count;

endmodule : wdlvh_top

// ===== hdl/wdlvh_regs.svh
// timing and width constants of the watchdog and low-voltage hold supervisor
`ifndef WDLVH_REGS_SVH
`define WDLVH_REGS_SVH

// master clock and the nominal system clock rate
`define WDLVH_CLK_HZ 40000000
`define WDLVH_SYS_HZ 2000000
`define WDLVH_DIV_RATIO (`WDLVH_CLK_HZ / `WDLVH_SYS_HZ)
`define WDLVH_DIV_W 8

// watchdog terminal time and its count in system ticks
`define WDLVH_WDT_TIMEOUT_MS 1000
`define WDLVH_MS_PER_S 1000
`define WDLVH_WDT_TICKS ((64'd`WDLVH_SYS_HZ * 64'd`WDLVH_WDT_TIMEOUT_MS) / 64'd`WDLVH_MS_PER_S)
`define WDLVH_WDT_W 26

// length of the chip reset pulse, in system ticks
`define WDLVH_RST_PULSE_TICKS 16
`define WDLVH_RST_W 8

// ticks the low-voltage flag must stand before it is believed
`define WDLVH_LV_FILTER_TICKS 4
`define WDLVH_FLT_W 4

// reset values
`define WDLVH_ZERO_DIV 8'h00
`define WDLVH_ZERO_RST 8'h00
`define WDLVH_ZERO_FLT 4'h0
`define WDLVH_ZERO_WDT 26'h0000000

`endif

// ===== hdl/wdlvh_pkg.sv
// types of the watchdog and low-voltage hold supervisor
`include "wdlvh_regs.svh"

package wdlvh_pkg;

    typedef enum logic [2:0] {
        WDLVH_RUN  = 3'b001,
        WDLVH_PEND = 3'b010,
        WDLVH_HOLD = 3'b100
    } wdlvh_hold_t;

    typedef struct packed {
        logic [`WDLVH_DIV_W-1:0] div;
        logic tick;
        wdlvh_hold_t hold;
        logic [`WDLVH_FLT_W-1:0] flt;
        logic lv_filt;
        logic [`WDLVH_RST_W-1:0] rst_cnt;
        logic chip_reset;
    } wdlvh_top_state_t;

    typedef struct packed {
        logic [`WDLVH_WDT_W-1:0] count;
        logic expire;
    } wdlvh_cnt_state_t;

endpackage : wdlvh_pkg

// ===== hdl/wdlvh_wdt_if.sv
// link between the supervisor control and its watchdog counter
`timescale 1ns/100ps
`include "wdlvh_regs.svh"

interface wdlvh_wdt_if;
    logic tick;
    logic clear;
    logic expire;
    logic [`WDLVH_WDT_W-1:0] count;

    modport ctrl (
        output tick,
        output clear,
        input expire,
        input count
    );

    modport cnt (
        input tick,
        input clear,
        output expire,
        output count
    );
endinterface : wdlvh_wdt_if

// ===== hdl/wdlvh_countdown.sv
// supervisory countdown: counts system ticks up to the terminal count
`timescale 1ns/100ps
`include "wdlvh_regs.svh"

module wdlvh_countdown
    import wdlvh_pkg::*;
#(
    parameter int TIMEOUT_TICKS = int'(`WDLVH_WDT_TICKS)
) (
    input wire logic clock,
    input wire logic rst,
    wdlvh_wdt_if.cnt wdt
);

    localparam logic [`WDLVH_WDT_W-1:0] LAST = `WDLVH_WDT_W'(TIMEOUT_TICKS - 1);

    initial begin
        if (TIMEOUT_TICKS < 2 || longint'(TIMEOUT_TICKS) > (64'd1 << `WDLVH_WDT_W)) begin
            $error("wdlvh_countdown: TIMEOUT_TICKS out of range");
        end
    end

    wdlvh_cnt_state_t s;
    wdlvh_cnt_state_t next_s;

    always_comb begin
        next_s = s;
        next_s.expire = 1'b0;
        if (wdt.clear) begin
            next_s.count = `WDLVH_ZERO_WDT;
        end else if (wdt.tick) begin
            if (s.count == LAST) begin
                next_s.count = `WDLVH_ZERO_WDT;
                next_s.expire = 1'b1;
            end else begin
                next_s.count = s.count + `WDLVH_WDT_W'(1);
            end
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign wdt.expire = s.expire;
    assign wdt.count = s.count;

endmodule : wdlvh_countdown

// ===== tb/wdlvh_top_assertions.sv
// concurrent checks on the supervisor top ports
`timescale 1ns/100ps
`include "wdlvh_regs.svh"
module wdlvh_top_assertions #(
    parameter int TIMEOUT_TICKS = 50
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic wdt_clear,
    input wire logic low_voltage,
    input wire logic instr_done,
    input wire logic chip_reset,
    input wire logic hold_active,
    input wire logic hold_pending,
    input wire logic state_update_en,
    input wire logic sys_tick,
    input wire logic internal_ring_osc_en,
    input wire logic [`WDLVH_WDT_W-1:0] supervisory_countdown
);
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    sequence s_supply_ok; !low_voltage [*8]; endsequence
    sequence s_pulse; chip_reset [*6]; endsequence
    a_clear_zeroes: assert property (wdt_clear |=> supervisory_countdown == 0)
        else $error("clear did not zero count");
    a_count_steps: assert property (sys_tick && !wdt_clear && !chip_reset &&
        supervisory_countdown != TIMEOUT_TICKS - 1 |=>
        supervisory_countdown == $past(supervisory_countdown) + 1)
        else $error("count did not advance");
    a_expire_reset: assert property (sys_tick && !wdt_clear && !chip_reset &&
        supervisory_countdown == TIMEOUT_TICKS - 1 |-> ##[1:2] chip_reset)
        else $error("no reset at terminal count");
    a_reset_pulse: assert property ($rose(chip_reset) |-> s_pulse ##[1:8] !chip_reset)
        else $error("reset pulse length wrong");
    a_tick_period: assert property (sys_tick |=> !sys_tick)
        else $error("tick too frequent");
    a_hold_request: assert property ($rose(hold_pending) |-> $past(low_voltage))
        else $error("hold requested without low supply");
    a_hold_boundary: assert property ($rose(hold_active) |-> $past(instr_done))
        else $error("hold entered mid instruction");
    a_pend_to_hold: assert property (hold_pending && instr_done && $past(low_voltage) &&
        !chip_reset |=> hold_active)
        else $error("pending hold not taken");
    a_hold_exit: assert property (hold_active ##0 s_supply_ok |=> !hold_active)
        else $error("hold not left after recovery");
    a_osc_running: assert property (internal_ring_osc_en)
        else $error("oscillator gated");
    a_update_gate: assert property (state_update_en == (sys_tick && !hold_active &&
        !chip_reset))
        else $error("update enable wrong");
endmodule : wdlvh_top_assertions

// ===== tb/test_wdlvh_top.sv
// self-checking bench for the supervisor top
`timescale 1ns/100ps
`include "wdlvh_regs.svh"
module test_wdlvh_top;
    localparam int T = 50;
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic wdt_clear = 1'b0;
    logic low_voltage = 1'b0;
    logic instr_done = 1'b0;
    logic chip_reset, hold_active, hold_pending, state_update_en, sys_tick, osc_en;
    logic [`WDLVH_WDT_W-1:0] supervisory_countdown;
    logic [`WDLVH_WDT_W-1:0] model = '0;
    logic chk = 1'b0;
    int bad_count = 0;
    int tests_run = 0;
    int n;
    integer seed = 32'hce5ebc1e;
    always #12.5 clock = ~clock;
    wdlvh_top #(.DIV_RATIO(2), .TIMEOUT_TICKS(T), .RST_PULSE_TICKS(4), .LV_FILTER_TICKS(2))
    wdlvh_top_i (.clock(clock), .rst(rst), .wdt_clear(wdt_clear), .low_voltage(low_voltage),
        .instr_done(instr_done), .chip_reset(chip_reset), .hold_active(hold_active),
        .hold_pending(hold_pending), .state_update_en(state_update_en), .sys_tick(sys_tick),
        .internal_ring_osc_en(osc_en), .supervisory_countdown(supervisory_countdown));
    task check(input logic [`WDLVH_WDT_W-1:0] seen, input logic [`WDLVH_WDT_W-1:0] exp);
        tests_run++;
        if (seen !== exp) begin
            bad_count++;
            $display("ERROR %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task wrap_up;
        if (bad_count == 0 && tests_run > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : wrap_up
    function logic [`WDLVH_WDT_W-1:0] next_cnt(input logic [`WDLVH_WDT_W-1:0] cur,
        input logic clr, input logic tick);
        if (clr) return '0;
        if (tick) return (cur == T - 1) ? '0 : cur + 1'b1;
        return cur;
    endfunction : next_cnt
    task clr_pulse;
        @(posedge clock);
        wdt_clear <= 1'b1;
        @(posedge clock);
        wdt_clear <= 1'b0;
    endtask : clr_pulse
    // waits for chip reset to reach lvl, counting ticks meanwhile
    task await_reset(input logic lvl);
        n = 0;
        for (int k = 0; k < 4 * T && chip_reset !== lvl; k++) begin
            // sample on the falling edge, where the registered outputs have settled
            @(negedge clock);
            if (sys_tick === 1'b1 && chip_reset !== lvl) n++;
        end
        if (chip_reset !== lvl) begin
            bad_count++;
            wrap_up;
        end
    endtask : await_reset
    always @(posedge clock) begin
        if (chk) begin
            check(supervisory_countdown, model);
            check(chip_reset, 1'b0);
        end
        if (hold_active === 1'b1) check(state_update_en, 1'b0);
        model = next_cnt(model, wdt_clear, sys_tick);
    end
    initial begin
        repeat (16) @(posedge clock);
        rst <= 1'b0;
        @(posedge clock);
        check(osc_en, 1'b1);
        clr_pulse;
        chk <= 1'b1;
        for (int i = 0; i < 400; i++) begin
            @(posedge clock);
            wdt_clear <= (($random(seed) & 7) == 0) || (supervisory_countdown > 30);
            instr_done <= ($random(seed) & 3) == 0;
            if (i % 40 == 0) low_voltage <= $random(seed);
        end
        @(posedge clock);
        {instr_done, low_voltage, wdt_clear} <= 3'b101;
        @(posedge clock);
        {instr_done, wdt_clear} <= 2'b00;
        repeat (12) @(posedge clock);
        low_voltage <= 1'b1;
        repeat (10) @(posedge clock);
        check(hold_pending, 1'b1);
        check(hold_active, 1'b0);
        instr_done <= 1'b1;
        @(posedge clock);
        instr_done <= 1'b0;
        repeat (2) @(posedge clock);
        check(hold_active, 1'b1);
        check(osc_en, 1'b1);
        chk <= 1'b0;
        clr_pulse;
        await_reset(1'b1);
        check(26'(n), 26'(T));
        // hold is forced off one clock after chip reset rises
        @(negedge clock);
        check(hold_active, 1'b0);
        await_reset(1'b0);
        repeat (12) @(posedge clock);
        instr_done <= 1'b1;
        @(posedge clock);
        instr_done <= 1'b0;
        repeat (2) @(posedge clock);
        check(hold_active, 1'b1);
        low_voltage <= 1'b0;
        repeat (10) @(posedge clock);
        check(hold_active, 1'b0);
        wrap_up;
    end
endmodule : test_wdlvh_top
bind wdlvh_top wdlvh_top_assertions #(.TIMEOUT_TICKS(TIMEOUT_TICKS)) wdlvh_top_assertions_i (
    .clock(clock), .rst(rst), .wdt_clear(wdt_clear), .low_voltage(low_voltage),
    .instr_done(instr_done), .chip_reset(chip_reset), .hold_active(hold_active),
    .hold_pending(hold_pending), .state_update_en(state_update_en), .sys_tick(sys_tick),
    .internal_ring_osc_en(internal_ring_osc_en), .supervisory_countdown(supervisory_countdown));
